// file: rtl/thermal_alarm_cfg.svh
`ifndef THERMAL_ALARM_CFG_SVH
`define THERMAL_ALARM_CFG_SVH

// ====================================================================
// Register select codes on the register port
`define THA_SEL_TEMP        2'h0
`define THA_SEL_CFG         2'h1
`define THA_SEL_LOWER       2'h2
`define THA_SEL_UPPER       2'h3

// ====================================================================
// Reset values
`define THA_UPPER_RESET     16'h5000
`define THA_LOWER_RESET     16'h4b00
`define THA_TEMP_RESET      16'h8000
`define THA_CFG_RESET       5'h00

// ====================================================================
// Field positions
`define THA_CFG_SHDN_BIT    0
`define THA_CFG_INT_BIT     1
`define THA_CFG_POL_BIT     2
`define THA_CFG_QLO_BIT     3
`define THA_CFG_QHI_BIT     4
`define THA_CFG_MSB         4
`define THA_CODE_MSB        15
`define THA_CODE_LSB        7

// ====================================================================
// Queue depths for select codes 00, 01, 10, 11
`define THA_QDEPTH_0        3'h1
`define THA_QDEPTH_1        3'h2
`define THA_QDEPTH_2        3'h4
`define THA_QDEPTH_3        3'h6

// ====================================================================
// Conversion timing
`define THA_CONV_TIME_MS    133
`define THA_CLK_KHZ         100000
`define THA_CONV_CYCLES     (`THA_CONV_TIME_MS * `THA_CLK_KHZ)

`endif

// file: rtl/thermal_alarm_pkg.sv
`include "thermal_alarm_cfg.svh"

package thermal_alarm_pkg;

   // ====================================================================
   // Fault queue states
   typedef enum logic [3:0] {
      FQ_WATCH_HIGH = 4'h1,
      FQ_ALARM_HIGH = 4'h2,
      FQ_WATCH_LOW  = 4'h4,
      FQ_ALARM_LOW  = 4'h8
   } fq_state_t;

   typedef logic [8:0] thr_code_t;

   // Depth select code to number of consecutive faults
   function automatic logic [2:0] queue_depth(input logic [1:0] sel);
      case (sel)
         2'h0:    queue_depth = `THA_QDEPTH_0;
         2'h1:    queue_depth = `THA_QDEPTH_1;
         2'h2:    queue_depth = `THA_QDEPTH_2;
         default: queue_depth = `THA_QDEPTH_3;
      endcase
   endfunction

endpackage

// file: rtl/fault_queue_if.sv
`timescale 1ns/100ps

// ====================================================================
// Link between the register side and the fault queue
interface fault_queue_if;
   logic       conv_done;
   logic       over;
   logic       under;
   logic       int_mode;
   logic [1:0] depth_sel;
   logic       clear;
   logic       reg_read;
   logic       alarm;
   logic [2:0] count;

   modport ctrl  (output conv_done, over, under, int_mode, depth_sel, clear, reg_read,
                  input  alarm, count);
   modport queue (input  conv_done, over, under, int_mode, depth_sel, clear, reg_read,
                  output alarm, count);
endinterface

// file: rtl/fault_queue.sv
`timescale 1ns/100ps

module fault_queue
   import thermal_alarm_pkg::*;
(
   // Clock and reset
   input  wire logic  i_core_clk,
   input  wire logic  i_rst,
   // Queue link
   fault_queue_if.queue fq
);

   fq_state_t  state_reg;
   fq_state_t  state_next;
   logic [2:0] count_reg;
   logic       qualify;
   logic       hit;

   // ====================================================================
   // Qualifying result for the watched fault type
   always_comb begin
      case (state_reg)
         FQ_WATCH_HIGH: qualify = fq.over;
         FQ_ALARM_HIGH: qualify = fq.under & ~fq.int_mode;
         FQ_WATCH_LOW:  qualify = fq.under;
         default:       qualify = 1'b0;
      endcase
   end

   assign hit = fq.conv_done & qualify & ((count_reg + 3'h1) == queue_depth(fq.depth_sel));

   // Next state: trip, release, and read acknowledge
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FQ_WATCH_HIGH: if (hit) state_next = FQ_ALARM_HIGH;
         FQ_ALARM_HIGH: begin
            if (fq.int_mode && fq.reg_read) state_next = FQ_WATCH_LOW;
            else if (hit) state_next = FQ_WATCH_HIGH;
         end
         FQ_WATCH_LOW:  if (hit) state_next = FQ_ALARM_LOW;
         FQ_ALARM_LOW:  if (fq.reg_read) state_next = FQ_WATCH_HIGH;
         default:       state_next = FQ_WATCH_HIGH;
      endcase
   end

   // State register; any clear returns to watching the upper limit
   always_ff @(posedge i_core_clk) begin
      if (i_rst || fq.clear) state_reg <= FQ_WATCH_HIGH;
      else state_reg <= state_next;
   end

   // Consecutive fault counter; an in-tolerance result restarts it
   always_ff @(posedge i_core_clk) begin
      if (i_rst || fq.clear) count_reg <= 3'h0;
      else if (fq.conv_done) begin
         if (!qualify || hit) count_reg <= 3'h0;
         else count_reg <= count_reg + 3'h1;
      end
   end

   assign fq.alarm = (state_reg == FQ_ALARM_HIGH) || (state_reg == FQ_ALARM_LOW);
   assign fq.count = count_reg;

   // ====================================================================
   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   depth_bound_a: assert property (count_reg < queue_depth(fq.depth_sel))
      else $error("fault count reached the queue depth");
   trip_alarm_a: assert property (state_reg == FQ_WATCH_HIGH && hit && !fq.clear |=> fq.alarm)
      else $error("alarm not raised at queue depth");
   int_hold_a: assert property (fq.int_mode && fq.alarm && !fq.reg_read && !fq.clear |=> fq.alarm)
      else $error("interrupt alarm dropped without a read");
   in_tol_a: assert property (fq.conv_done && !qualify && !fq.alarm |=> count_reg == 3'h0)
      else $error("partial tally kept after in-tolerance result");

endmodule // fault_queue

// file: rtl/thermal_alarm_fault_queue.sv
`timescale 1ns/100ps

// How it works
// - Thresholds keep bits 15..7, low bits zero
// - Thresholds reset to 5000 and 4b00 hex
// - Result left-justified two's complement, 8000 after reset
// - Count consecutive out-of-tolerance results before toggling
// - Queue depth one, two, four or six
// - In-tolerance result while idle clears the count
// - Reset, shutdown and threshold/config writes clear count
// - Reset, shutdown and write clears deassert the alarm
// - Comparator mode trips after depth results above upper
// - Comparator mode releases after depth results below lower
// - Interrupt mode alternates watched fault type
// - Interrupt alarm held until any register read
// - Every activation needs depth; clear watches upper
// - Shutdown stops conversions, result forced 8000
// - After shutdown result stays 8000 until conversion
// - Shutdown holds the fault count in reset
// - Config bits: shutdown, interrupt mode, polarity
// - Config bits 4..3 select queue depth
// - Conversions run continuously every 133 ms

`include "thermal_alarm_cfg.svh"

module thermal_alarm_fault_queue
   import thermal_alarm_pkg::*;
#(
   parameter int CONV_CYCLES = `THA_CONV_CYCLES
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // Register port from the serial slave
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [1:0]  i_reg_sel,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   output logic             o_reg_rvalid,
   // Converter
   input  wire logic [8:0]  i_adc_code,
   output logic             o_conv_done,
   // Alarm and status
   output logic             o_alarm_output,
   output logic             o_shutdown
);

   localparam int CNT_W = (CONV_CYCLES > 2) ? $clog2(CONV_CYCLES) : 1;

   // ====================================================================
   // Parameter check, refused at elaboration; the timer needs two states
   if (CONV_CYCLES < 2 || CONV_CYCLES > (1 << 30)) begin : g_bad_conv
      $error("CONV_CYCLES out of range");
   end

   // ====================================================================
   // Declarations
   logic [`THA_CFG_MSB:0] cfg_reg;
   thr_code_t             upper_reg;
   thr_code_t             lower_reg;
   logic [15:0]           temp_reg;
   logic [8:0]            adc_meta_reg;
   logic [8:0]            adc_sync_reg;
   logic [CNT_W-1:0]      conv_cnt_reg;
   logic                  conv_tick;
   logic                  shdn;
   logic                  int_mode;
   logic                  pol_high;
   logic                  thr_write;
   logic [15:0]           rdata_next;
   logic                  conv_done_reg;
   logic                  rvalid_reg;
   logic                  alarm_pin_reg;

   fault_queue_if fq_link ();

   // ====================================================================
   // Configuration fields
   assign shdn     = cfg_reg[`THA_CFG_SHDN_BIT];
   assign int_mode = cfg_reg[`THA_CFG_INT_BIT];
   assign pol_high = cfg_reg[`THA_CFG_POL_BIT];

   // Any write that lands in a writable register
   assign thr_write = i_reg_wr && (i_reg_sel != `THA_SEL_TEMP);

   // Configuration register, reserved bits dropped
   always_ff @(posedge i_core_clk) begin
      if (i_rst) cfg_reg <= `THA_CFG_RESET;
      else if (i_reg_wr && i_reg_sel == `THA_SEL_CFG) begin
         cfg_reg <= i_reg_wdata[`THA_CFG_MSB:0];
      end
   end

   // Upper threshold, only the nine code bits are stored
   always_ff @(posedge i_core_clk) begin
      if (i_rst) upper_reg <= 9'(`THA_UPPER_RESET >> `THA_CODE_LSB);
      else if (i_reg_wr && i_reg_sel == `THA_SEL_UPPER) begin
         upper_reg <= i_reg_wdata[`THA_CODE_MSB:`THA_CODE_LSB];
      end
   end

   // Lower threshold, only the nine code bits are stored
   always_ff @(posedge i_core_clk) begin
      if (i_rst) lower_reg <= 9'(`THA_LOWER_RESET >> `THA_CODE_LSB);
      else if (i_reg_wr && i_reg_sel == `THA_SEL_LOWER) begin
         lower_reg <= i_reg_wdata[`THA_CODE_MSB:`THA_CODE_LSB];
      end
   end

   // ====================================================================
   // Converter code synchroniser; the code is held steady by the
   // converter, so a per-bit two-stage capture is enough
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         adc_meta_reg <= 9'h000;
         adc_sync_reg <= 9'h000;
      end else begin
         adc_meta_reg <= i_adc_code;
         adc_sync_reg <= adc_meta_reg;
      end
   end

   // ====================================================================
   // Conversion timer, stopped and rewound in shutdown
   always_ff @(posedge i_core_clk) begin
      if (i_rst || shdn) conv_cnt_reg <= '0;
      else if (conv_tick) conv_cnt_reg <= '0;
      else conv_cnt_reg <= conv_cnt_reg + 1'b1;
   end

   // One result per period, independent of register traffic
   assign conv_tick = !shdn && (conv_cnt_reg == CNT_W'(CONV_CYCLES - 1));

   // Temperature result; stays at the blank code until a conversion
   always_ff @(posedge i_core_clk) begin
      if (i_rst || shdn) temp_reg <= `THA_TEMP_RESET;
      else if (conv_tick) temp_reg <= {adc_sync_reg, 7'h00};
   end

   // Conversion done pulse for the outside
   always_ff @(posedge i_core_clk) begin
      if (i_rst) conv_done_reg <= 1'b0;
      else conv_done_reg <= conv_tick;
   end

   // ====================================================================
   // Fault queue link
   assign fq_link.conv_done = conv_tick;
   assign fq_link.over      = $signed(adc_sync_reg) > $signed(upper_reg);
   assign fq_link.under     = $signed(adc_sync_reg) < $signed(lower_reg);
   assign fq_link.int_mode  = int_mode;
   assign fq_link.depth_sel = cfg_reg[`THA_CFG_QHI_BIT:`THA_CFG_QLO_BIT];
   assign fq_link.clear     = shdn || thr_write;
   assign fq_link.reg_read  = i_reg_rd;

   fault_queue u_fault_queue (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .fq         (fq_link.queue)
   );

   // ====================================================================
   // Alarm pin with selectable polarity
   always_ff @(posedge i_core_clk) begin
      if (i_rst) alarm_pin_reg <= 1'b1;
      else alarm_pin_reg <= pol_high ? fq_link.alarm : !fq_link.alarm;
   end

   // ====================================================================
   // Read data mux; low threshold bits read zero
   always_comb begin
      case (i_reg_sel)
         `THA_SEL_TEMP:  rdata_next = temp_reg;
         `THA_SEL_CFG:   rdata_next = {11'h000, cfg_reg};
         `THA_SEL_LOWER: rdata_next = {lower_reg, 7'h00};
         default:        rdata_next = {upper_reg, 7'h00};
      endcase
   end

   // Read data register and valid pulse
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_reg_rdata <= 16'h0000;
         rvalid_reg  <= 1'b0;
      end else begin
         if (i_reg_rd) o_reg_rdata <= rdata_next;
         rvalid_reg <= i_reg_rd;
      end
   end

   assign o_reg_rvalid   = rvalid_reg;
   assign o_conv_done    = conv_done_reg;
   assign o_alarm_output = alarm_pin_reg;
   assign o_shutdown     = shdn;

   // ====================================================================
   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   // Threshold reads show zero in the low bits
   thr_low_zero_a: assert property (
      i_reg_rd && (i_reg_sel == `THA_SEL_UPPER || i_reg_sel == `THA_SEL_LOWER)
      |=> o_reg_rvalid && o_reg_rdata[6:0] == 7'h00)
      else $error("threshold low bits not zero");

   // Reset values after power-up
   reset_values_a: assert property (
      $past(i_rst) |-> upper_reg == 9'h0a0 && lower_reg == 9'h096 && temp_reg == 16'h8000)
      else $error("reset value wrong");

   // Conversion stores the synchronised code left-justified
   temp_format_a: assert property (
      conv_tick |=> temp_reg == {$past(adc_sync_reg), 7'h00})
      else $error("temperature result not left-justified");

   // Shutdown blanks the result and stops the timer
   shdn_blank_a: assert property (
      shdn |=> temp_reg == 16'h8000 && !conv_tick && conv_cnt_reg == '0)
      else $error("shutdown did not blank result");

   // Leaving shutdown keeps the blank code for a while
   shdn_exit_a: assert property (
      shdn ##1 !shdn |-> temp_reg == 16'h8000 ##1 temp_reg == 16'h8000)
      else $error("result changed right after shutdown");

   // Shutdown keeps the fault count at zero
   shdn_count_a: assert property (
      shdn |=> fq_link.count == 3'h0 && !fq_link.alarm)
      else $error("fault count moved in shutdown");

   // Writes to threshold or config clear the queue
   write_clear_a: assert property (
      thr_write |=> fq_link.count == 3'h0)
      else $error("write did not clear fault count");

   // Every clear drops the alarm
   clear_alarm_a: assert property (
      fq_link.clear |=> !fq_link.alarm)
      else $error("alarm survived a queue clear");

   // Interrupt alarm cleared by any read
   read_clear_a: assert property (
      int_mode && fq_link.alarm && i_reg_rd && !conv_tick |=> !fq_link.alarm)
      else $error("read did not clear interrupt alarm");

   // Pin follows alarm with the selected polarity
   pin_pol_a: assert property (
      ##1 o_alarm_output == ($past(pol_high) ? $past(fq_link.alarm) : !$past(fq_link.alarm)))
      else $error("alarm pin polarity wrong");

   // Alarm may only rise on a conversion
   rise_cause_a: assert property (
      $rose(fq_link.alarm) |-> $past(conv_tick))
      else $error("alarm rose without a conversion");

   // Comparator release only on a clear or on a conversion below the lower limit
   comp_release_a: assert property (
      !int_mode && $fell(fq_link.alarm) |-> $past(fq_link.clear) || ($past(conv_tick) && $past(fq_link.under)))
      else $error("comparator alarm released without cause");

   // Comparator alarm only moves on a conversion or a clear
   comp_hold_a: assert property (
      !int_mode && fq_link.alarm && !conv_tick && !fq_link.clear |=> fq_link.alarm)
      else $error("comparator alarm dropped between conversions");

   // Read valid is one pulse right after each read strobe
   rvalid_pulse_a: assert property (
      i_reg_rd |=> o_reg_rvalid)
      else $error("read valid missing after read");

   // No read valid without a read strobe
   rvalid_only_a: assert property (
      !i_reg_rd |=> !o_reg_rvalid)
      else $error("read valid without a read");

   // Configuration reads show the stored bits, reserved bits zero
   cfg_read_a: assert property (
      i_reg_rd && i_reg_sel == `THA_SEL_CFG |=> o_reg_rdata == {11'h000, $past(cfg_reg)})
      else $error("configuration read data wrong");

   // Temperature reads return the latest result
   temp_read_a: assert property (
      i_reg_rd && i_reg_sel == `THA_SEL_TEMP |=> o_reg_rdata == $past(temp_reg))
      else $error("temperature read data wrong");

   // Result low bits always zero
   temp_low_zero_a: assert property (
      temp_reg[6:0] == 7'h00)
      else $error("temperature low bits not zero");

   // Upper threshold write keeps the code bits only
   upper_write_a: assert property (
      i_reg_wr && i_reg_sel == `THA_SEL_UPPER
      |=> upper_reg == $past(i_reg_wdata[`THA_CODE_MSB:`THA_CODE_LSB]))
      else $error("upper threshold write lost");

   // Conversion done follows each tick, and only a tick
   conv_done_a: assert property (
      conv_tick |=> o_conv_done)
      else $error("conversion done pulse missing");

   conv_quiet_a: assert property (
      !conv_tick |=> !o_conv_done)
      else $error("conversion done without a tick");

   // Timer never passes the end of the period
   timer_bound_a: assert property (
      conv_cnt_reg <= CNT_W'(CONV_CYCLES - 1))
      else $error("conversion timer overran");

   // Shutdown keeps the queue cleared every cycle
   shdn_clear_a: assert property (
      shdn |-> fq_link.clear)
      else $error("queue not held clear in shutdown");

   // Main scenarios
   comp_trip_c: cover property (!int_mode && !shdn ##1 $rose(fq_link.alarm));
   int_low_c: cover property (int_mode && fq_link.alarm && fq_link.under ##1 !fq_link.alarm);
   shdn_exit_c: cover property (shdn ##1 !shdn ##[1:1000] $changed(temp_reg));
   deep_queue_c: cover property (fq_link.depth_sel == 2'h3 && fq_link.count == 3'h5);

endmodule // thermal_alarm_fault_queue

// file: testbench/host_model.sv
`timescale 1ns/100ps

// ====================================================================
// Register master standing in for the serial slave side
module host_model (
   // Clock
   input  wire logic        i_core_clk,
   // Register requests
   output logic             o_reg_wr,
   output logic             o_reg_rd,
   output logic      [1:0]  o_reg_sel,
   output logic      [15:0] o_reg_wdata,
   // Read answer
   input  wire logic [15:0] i_reg_rdata,
   input  wire logic        i_reg_rvalid
);
   // Idle bus at time zero
   initial begin
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_sel   = 2'h0;
      o_reg_wdata = 16'h0000;
   end

   // One-cycle write strobe; released lines show the inverse
   task automatic write(input logic [1:0] sel, input logic [15:0] data);
      @(posedge i_core_clk);
      #1;
      o_reg_sel   = sel;
      o_reg_wdata = data;
      o_reg_wr    = 1'b1;
      @(posedge i_core_clk);
      #1;
      o_reg_wr    = 1'b0;
      o_reg_sel   = ~sel;
      o_reg_wdata = ~data;
   endtask

   // One-cycle read strobe; answer taken the cycle after
   task automatic read(input logic [1:0] sel, output logic [15:0] data, output logic valid);
      @(posedge i_core_clk);
      #1;
      o_reg_sel = sel;
      o_reg_rd  = 1'b1;
      @(posedge i_core_clk);
      #1;
      o_reg_rd  = 1'b0;
      o_reg_sel = ~sel;
      data      = i_reg_rdata;
      valid     = i_reg_rvalid;
   endtask
endmodule // host_model

// file: testbench/testbench.sv
`timescale 1ns/100ps
`include "thermal_alarm_cfg.svh"

module testbench;
   localparam int CONV = 20;

   logic        i_core_clk;
   logic        i_rst;
   logic [8:0]  adc_code;
   logic        reg_wr;
   logic        reg_rd;
   logic [1:0]  reg_sel;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic        conv_done;
   logic        alarm_pin;
   logic        shutdown;
   logic        pol = 1'b0;
   int          err_count = 0;
   int          checks = 0;
   int          n;
   logic [8:0]  codes [6] = '{9'h0fa, 9'h1ce, 9'h0a0, 9'h0a1, 9'h096, 9'h095};
   logic        trip [6]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   int          depth [4] = '{1, 2, 4, 6};

   // ====================================================================
   // Clock and instances
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   thermal_alarm_fault_queue #(.CONV_CYCLES(CONV)) DUT (
      .i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_sel(reg_sel), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
      .i_adc_code(adc_code), .o_conv_done(conv_done),
      .o_alarm_output(alarm_pin), .o_shutdown(shutdown));

   host_model host (
      .i_core_clk(i_core_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_sel(reg_sel),
      .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid));

   // ====================================================================
   // Shared tasks
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   task automatic wait_cyc(input int k);
      repeat (k) @(posedge i_core_clk);
      #1;
   endtask

   task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      host.read(sel, d, v);
      check("read valid", 16'h0001, {15'h0, v});
      check("read data", exp, d);
   endtask

   // Write, then let the pin follow
   task automatic wr(input logic [1:0] sel, input logic [15:0] data);
      host.write(sel, data);
      if (sel == `THA_SEL_CFG) pol = data[2];
      wait_cyc(1);
   endtask

   // Present a code and wait for its conversion and the pin
   task automatic conv(input logic [8:0] code);
      int k;
      adc_code = code;
      k = 0;
      do begin
         wait_cyc(1);
         k++;
      end while (conv_done !== 1'b1 && k < 3 * CONV);
      check("conv done", 16'h0001, {15'h0, conv_done});
      wait_cyc(1);
   endtask

   task automatic convn(input logic [8:0] code, input int k);
      repeat (k) conv(code);
   endtask

   task automatic alarm(input logic act);
      check("alarm pin", {15'h0, pol ? act : ~act}, {15'h0, alarm_pin});
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (10000) @(posedge i_core_clk);
      err_count++;
      $display("wrong value watchdog expected end seen timeout");
      stop_test;
   end

   // ====================================================================
   // Test sequence
   initial begin
      i_rst    = 1'b1;
      adc_code = 9'h032;
      repeat (6) @(posedge i_core_clk);
      #1;
      i_rst = 1'b0;
      alarm(1'b0);
      check("shutdown", 16'h0000, {15'h0, shutdown});
      rd(`THA_SEL_UPPER, 16'h5000);
      rd(`THA_SEL_LOWER, 16'h4b00);
      rd(`THA_SEL_TEMP, 16'h8000);
      rd(`THA_SEL_CFG, 16'h0000);
      $display("test reset done");

      wr(`THA_SEL_UPPER, 16'hffff);
      rd(`THA_SEL_UPPER, 16'hff80);
      wr(`THA_SEL_UPPER, 16'h5000);
      wr(`THA_SEL_CFG, 16'hffff);
      rd(`THA_SEL_CFG, 16'h001f);
      wr(`THA_SEL_CFG, 16'h0000);
      rd(`THA_SEL_TEMP, 16'h8000);
      $display("test fields done");

      // Comparator trip and release at the exact boundaries
      for (int i = 0; i < 6; i++) begin
         conv(codes[i]);
         rd(`THA_SEL_TEMP, {codes[i], 7'h0});
         alarm(trip[i]);
      end
      $display("test compare done");

      // Every depth code, active-high pin
      for (int s = 0; s < 4; s++) begin
         wr(`THA_SEL_CFG, {11'h0, 2'(s), 3'b100});
         alarm(1'b0);
         for (int j = 1; j < depth[s]; j++) begin
            conv(9'h0a1);
            alarm(1'b0);
         end
         conv(9'h0a1);
         alarm(1'b1);
      end
      $display("test depth done");

      // Partial counts cleared by a write and by an in-band result
      wr(`THA_SEL_CFG, 16'h0010);
      alarm(1'b0);
      convn(9'h0a1, 3);
      wr(`THA_SEL_LOWER, 16'h4b00);
      convn(9'h0a1, 3);
      alarm(1'b0);
      conv(9'h09b);
      convn(9'h0a1, 3);
      alarm(1'b0);
      conv(9'h0a1);
      alarm(1'b1);
      wr(`THA_SEL_UPPER, 16'h5000);
      alarm(1'b0);
      $display("test queue done");

      // Interrupt mode alternation and read release
      wr(`THA_SEL_CFG, 16'h0002);
      conv(9'h0a1);
      alarm(1'b1);
      conv(9'h0a0);
      alarm(1'b1);
      rd(`THA_SEL_LOWER, 16'h4b00);
      wait_cyc(1);
      alarm(1'b0);
      conv(9'h0a1);
      alarm(1'b0);
      conv(9'h095);
      alarm(1'b1);
      rd(`THA_SEL_TEMP, 16'h4a80);
      wait_cyc(1);
      alarm(1'b0);
      conv(9'h095);
      alarm(1'b0);
      conv(9'h0a1);
      alarm(1'b1);
      rd(`THA_SEL_CFG, 16'h0002);
      wait_cyc(1);
      alarm(1'b0);
      wr(`THA_SEL_CFG, 16'h0002);
      conv(9'h095);
      alarm(1'b0);
      conv(9'h0a1);
      alarm(1'b1);
      $display("test interrupt done");

      // Shutdown entry and exit
      wr(`THA_SEL_CFG, 16'h0000);
      conv(9'h0a1);
      alarm(1'b1);
      wr(`THA_SEL_CFG, 16'h0001);
      alarm(1'b0);
      check("shutdown", 16'h0001, {15'h0, shutdown});
      rd(`THA_SEL_TEMP, 16'h8000);
      n = 0;
      repeat (3 * CONV) begin
         wait_cyc(1);
         if (conv_done === 1'b1) n++;
      end
      check("conv in shutdown", 16'h0000, 16'(n));
      alarm(1'b0);
      wr(`THA_SEL_CFG, 16'h0000);
      rd(`THA_SEL_TEMP, 16'h8000);
      conv(9'h0a1);
      rd(`THA_SEL_TEMP, 16'h5080);
      alarm(1'b1);
      $display("test shutdown done");
      stop_test;
   end
endmodule // testbench
